// ==== verilog/e1s_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef E1S_REGS_SVH
`define E1S_REGS_SVH

`define E1S_OFF_CFG 12'h000
`define E1S_OFF_STATUS 12'h004
`define E1S_OFF_INT_STAT 12'h008
`define E1S_OFF_INT_MASK 12'h00C

`define E1S_CFG_DECL_LSB 0
`define E1S_CFG_CLR_LSB 8
`define E1S_CFG_DECL_RST 8'h20
`define E1S_CFG_CLR_RST 8'h20
`define E1S_N_MIN 8'h0A

`define E1S_ST_FLAG 0
`define E1S_ST_CLOCKED 1
`define E1S_ST_DRIVE 2

`define E1S_INT_DECL 0
`define E1S_INT_CLR 1
`define E1S_INT_MODE 2
`define E1S_INT_W 3
`define E1S_INT_MASK_RST 3'h0

`define E1S_CLK_NS 100
`define E1S_IVL_NS 488
`define E1S_IVL_CYC ((`E1S_IVL_NS + `E1S_CLK_NS - 1) / `E1S_CLK_NS)
`define E1S_PW_NS 244
`define E1S_PW_CYC ((`E1S_PW_NS / `E1S_CLK_NS) < 1 ? 1 : (`E1S_PW_NS / `E1S_CLK_NS))
`define E1S_EXT_PERIODS 2048
`define E1S_TCK_LOSS_IVL 4
`define E1S_TCK_TO_CYC (`E1S_TCK_LOSS_IVL * `E1S_IVL_CYC)

`endif

// ==== verilog/e1s_pkg.sv ====
// Types shared by the E1 channel logic
`include "e1s_regs.svh"
package e1s_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } e1s_apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } e1s_apb_rsp_t;

    typedef struct packed {
        logic positive;
        logic negative;
    } e1s_rails_t;

    typedef struct packed {
        logic rx_p_s1, rx_p_s2, rx_m_s1, rx_m_s2;
        logic ext_s1, ext_s2, ext_d;
        logic sel_s1, sel_s2;
        logic txp_s1, txp_s2, txm_s1, txm_s2;
        logic tck_s1, tck_s2, tck_d;
        logic rx_pos, rx_neg;
        logic [2:0] ivl_cnt;
        logic mark_seen;
        logic [7:0] run_cnt;
        logic [11:0] ext_cnt;
        logic ext_wait;
        logic flag;
        logic [5:0] clk_to;
        logic clocked;
        logic [1:0] pw_cnt;
        logic tx_p, tx_m;
        logic drv_en;
        logic [7:0] cfg_decl;
        logic [7:0] cfg_clr;
        logic [`E1S_INT_W-1:0] int_stat;
        logic [`E1S_INT_W-1:0] int_mask;
        logic irq;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } e1s_state_t;
endpackage : e1s_pkg

// ==== verilog/e1s_channel.sv ====
// One E1 channel: receive rails, signal-absent detector, transmit mode logic
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module e1s_channel (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire e1s_pkg::e1s_apb_req_t i_apb,
    output e1s_pkg::e1s_apb_rsp_t o_apb,
    input wire e1s_pkg::e1s_rails_t i_rx_line,
    input wire logic i_absence_delay_select,
    input wire logic i_absence_extension_clock,
    input wire e1s_pkg::e1s_rails_t i_tx_rail,
    input wire logic i_tx_bit_clock,
    output e1s_pkg::e1s_rails_t o_rx_rail,
    output var logic o_signal_absent_flag,
    output e1s_pkg::e1s_rails_t o_tx_line,
    output var logic o_tx_drive_en,
    output var logic o_irq
);
    import e1s_pkg::*;

    e1s_state_t st_reg;
    e1s_state_t st_next;

    logic ivl_end;
    logic ext_edge;
    logic tck_edge;
    logic toward;
    logic [7:0] n_need;
    logic [7:0] run_inc;
    logic acc;
    logic wr;
    logic [31:0] rdata;
    logic mapped;

    always_comb begin
        st_next = st_reg;
        ivl_end = (st_reg.ivl_cnt == 3'(`E1S_IVL_CYC - 1));
        ext_edge = st_reg.ext_s2 & ~st_reg.ext_d;
        tck_edge = st_reg.tck_s2 & ~st_reg.tck_d;
        toward = st_reg.flag ? st_reg.mark_seen : ~st_reg.mark_seen;
        n_need = st_reg.flag ? st_reg.cfg_clr : st_reg.cfg_decl;
        run_inc = (st_reg.run_cnt == 8'hFF) ? 8'hFF : st_reg.run_cnt + 8'h01;
        acc = i_apb.psel & i_apb.penable;
        wr = acc & i_apb.pwrite & st_reg.pready;
        mapped = 1'b1;
        rdata = 32'h0000_0000;

        // Pin synchronisers
        st_next.rx_p_s1 = i_rx_line.positive;
        st_next.rx_p_s2 = st_reg.rx_p_s1;
        st_next.rx_m_s1 = i_rx_line.negative;
        st_next.rx_m_s2 = st_reg.rx_m_s1;
        st_next.ext_s1 = i_absence_extension_clock;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_d = st_reg.ext_s2;
        st_next.sel_s1 = i_absence_delay_select;
        st_next.sel_s2 = st_reg.sel_s1;
        st_next.txp_s1 = i_tx_rail.positive;
        st_next.txp_s2 = st_reg.txp_s1;
        st_next.txm_s1 = i_tx_rail.negative;
        st_next.txm_s2 = st_reg.txm_s1;
        st_next.tck_s1 = i_tx_bit_clock;
        st_next.tck_s2 = st_reg.tck_s1;
        st_next.tck_d = st_reg.tck_s2;

        st_next.rx_pos = st_reg.rx_p_s2;
        st_next.rx_neg = st_reg.rx_m_s2;

        // Pulse-interval framing and mark detection
        st_next.ivl_cnt = ivl_end ? 3'h0 : st_reg.ivl_cnt + 3'h1;
        if (ivl_end) begin
            st_next.mark_seen = st_reg.rx_p_s2 | st_reg.rx_m_s2;
        end else begin
            st_next.mark_seen = st_reg.mark_seen | st_reg.rx_p_s2
                | st_reg.rx_m_s2;
        end

        // Extension clock periods counted while waiting in extended mode
        if (st_reg.ext_wait && ext_edge
            && st_reg.ext_cnt != 12'(`E1S_EXT_PERIODS)) begin
            st_next.ext_cnt = st_reg.ext_cnt + 12'h001;
        end

        if (ivl_end) begin
            if (!toward) begin
                st_next.run_cnt = 8'h00;
                st_next.ext_wait = 1'b0;
                st_next.ext_cnt = 12'h000;
            end else if (!st_reg.ext_wait) begin
                st_next.run_cnt = run_inc;
                if (run_inc >= n_need) begin
                    if (st_reg.sel_s2) begin
                        st_next.flag = ~st_reg.flag;
                        st_next.run_cnt = 8'h00;
                    end else begin
                        st_next.ext_wait = 1'b1;
                        st_next.ext_cnt = 12'h000;
                    end
                end
            end else if (st_reg.ext_cnt == 12'(`E1S_EXT_PERIODS)) begin
                st_next.flag = ~st_reg.flag;
                st_next.run_cnt = 8'h00;
                st_next.ext_wait = 1'b0;
                st_next.ext_cnt = 12'h000;
            end
        end

        // Transmit clock presence
        if (tck_edge) begin
            st_next.clk_to = 6'h00;
            st_next.clocked = 1'b1;
        end else if (st_reg.clk_to == 6'(`E1S_TCK_TO_CYC)) begin
            st_next.clocked = 1'b0;
        end else begin
            st_next.clk_to = st_reg.clk_to + 6'h01;
        end

        // Transmit pulse shaping
        if (st_reg.clocked) begin
            if (tck_edge) begin
                st_next.tx_p = st_reg.txp_s2 & ~st_reg.txm_s2;
                st_next.tx_m = st_reg.txm_s2 & ~st_reg.txp_s2;
                st_next.pw_cnt = 2'(`E1S_PW_CYC - 1);
            end else if (st_reg.pw_cnt != 2'h0) begin
                st_next.pw_cnt = st_reg.pw_cnt - 2'h1;
            end else begin
                st_next.tx_p = 1'b0;
                st_next.tx_m = 1'b0;
            end
        end else begin
            st_next.tx_p = st_reg.txp_s2 & ~st_reg.txm_s2;
            st_next.tx_m = st_reg.txm_s2 & ~st_reg.txp_s2;
            st_next.pw_cnt = 2'h0;
        end
        st_next.drv_en = 1'b1;
        if (st_reg.txp_s2 && st_reg.txm_s2) begin
            st_next.drv_en = 1'b0;
        end
        if (!st_reg.clocked && !st_reg.tck_s2) begin
            st_next.drv_en = 1'b0;
        end
        st_next.tx_p = st_next.tx_p & st_next.drv_en;
        st_next.tx_m = st_next.tx_m & st_next.drv_en;

        // Register reads
        case (i_apb.paddr)
            `E1S_OFF_CFG: begin
                rdata[`E1S_CFG_DECL_LSB +: 8] = st_reg.cfg_decl;
                rdata[`E1S_CFG_CLR_LSB +: 8] = st_reg.cfg_clr;
            end
            `E1S_OFF_STATUS: begin
                rdata[`E1S_ST_FLAG] = st_reg.flag;
                rdata[`E1S_ST_CLOCKED] = st_reg.clocked;
                rdata[`E1S_ST_DRIVE] = st_reg.drv_en;
            end
            `E1S_OFF_INT_STAT: rdata[`E1S_INT_W-1:0] = st_reg.int_stat;
            `E1S_OFF_INT_MASK: rdata[`E1S_INT_W-1:0] = st_reg.int_mask;
            default: mapped = 1'b0;
        endcase

        // APB: one wait state, write commits on the completing edge
        st_next.pready = acc & ~st_reg.pready;
        if (acc && !st_reg.pready) begin
            st_next.prdata = i_apb.pwrite ? 32'h0000_0000 : rdata;
            st_next.pslverr = ~mapped;
        end else if (st_reg.pready) begin
            st_next.prdata = 32'h0000_0000;
            st_next.pslverr = 1'b0;
        end

        if (wr && i_apb.paddr == `E1S_OFF_CFG) begin
            st_next.cfg_decl = (i_apb.pwdata[`E1S_CFG_DECL_LSB +: 8]
                < `E1S_N_MIN) ? `E1S_N_MIN
                : i_apb.pwdata[`E1S_CFG_DECL_LSB +: 8];
            st_next.cfg_clr = (i_apb.pwdata[`E1S_CFG_CLR_LSB +: 8]
                < `E1S_N_MIN) ? `E1S_N_MIN
                : i_apb.pwdata[`E1S_CFG_CLR_LSB +: 8];
        end
        if (wr && i_apb.paddr == `E1S_OFF_INT_MASK) begin
            st_next.int_mask = i_apb.pwdata[`E1S_INT_W-1:0];
        end
        if (wr && i_apb.paddr == `E1S_OFF_INT_STAT) begin
            st_next.int_stat = st_reg.int_stat
                & ~i_apb.pwdata[`E1S_INT_W-1:0];
        end
        // Events set after the clear so a coincident event survives
        if (st_next.flag && !st_reg.flag) begin
            st_next.int_stat[`E1S_INT_DECL] = 1'b1;
        end
        if (!st_next.flag && st_reg.flag) begin
            st_next.int_stat[`E1S_INT_CLR] = 1'b1;
        end
        if (st_next.clocked != st_reg.clocked) begin
            st_next.int_stat[`E1S_INT_MODE] = 1'b1;
        end
        st_next.irq = |(st_next.int_stat & st_next.int_mask);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg <= '0;
            st_reg.sel_s1 <= 1'b1;
            st_reg.sel_s2 <= 1'b1;
            // Pins idle high on their pull-ups, so no false edge after reset
            st_reg.tck_s1 <= 1'b1;
            st_reg.tck_s2 <= 1'b1;
            st_reg.tck_d <= 1'b1;
            st_reg.txp_s1 <= 1'b1;
            st_reg.txp_s2 <= 1'b1;
            st_reg.txm_s1 <= 1'b1;
            st_reg.txm_s2 <= 1'b1;
            st_reg.flag <= 1'b1;
            st_reg.cfg_decl <= `E1S_CFG_DECL_RST;
            st_reg.cfg_clr <= `E1S_CFG_CLR_RST;
            st_reg.int_mask <= `E1S_INT_MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_apb = '{pready: st_reg.pready, prdata: st_reg.prdata,
                     pslverr: st_reg.pslverr};
    assign o_rx_rail = '{positive: st_reg.rx_pos, negative: st_reg.rx_neg};
    assign o_signal_absent_flag = st_reg.flag;
    assign o_tx_line = '{positive: st_reg.tx_p, negative: st_reg.tx_m};
    assign o_tx_drive_en = st_reg.drv_en;
    assign o_irq = st_reg.irq;

    property p_rx_rail;
        @(posedge i_clk) disable iff (i_srst)
        !$past(i_srst, 3)
        |-> o_rx_rail.positive == $past(i_rx_line.positive, 3);
    endproperty
    a_rx_rail: assert property (p_rx_rail)
        else $error("rx rail lag wrong");

    property p_flag_boundary;
        @(posedge i_clk) disable iff (i_srst)
        $changed(o_signal_absent_flag) |-> $past(ivl_end);
    endproperty
    a_flag_boundary: assert property (p_flag_boundary)
        else $error("flag moved mid interval");

    property p_min_window;
        @(posedge i_clk) disable iff (i_srst)
        $changed(o_signal_absent_flag) |-> $past(st_reg.run_cnt) >= 8'h09;
    endproperty
    a_min_window: assert property (p_min_window)
        else $error("flag changed too fast");

    property p_auto_decl;
        @(posedge i_clk) disable iff (i_srst)
        ivl_end && st_reg.sel_s2 && !st_reg.flag && !st_reg.mark_seen
        && !st_reg.ext_wait && run_inc >= st_reg.cfg_decl
        |=> o_signal_absent_flag;
    endproperty
    a_auto_decl: assert property (p_auto_decl)
        else $error("absence not declared");

    property p_auto_clr;
        @(posedge i_clk) disable iff (i_srst)
        ivl_end && st_reg.sel_s2 && st_reg.flag && st_reg.mark_seen
        && !st_reg.ext_wait && run_inc >= st_reg.cfg_clr
        |=> !o_signal_absent_flag;
    endproperty
    a_auto_clr: assert property (p_auto_clr)
        else $error("absence not cleared");

    property p_ext_delay;
        @(posedge i_clk) disable iff (i_srst)
        $changed(o_signal_absent_flag) && $past(st_reg.ext_wait)
        |-> $past(st_reg.ext_cnt) == 12'h800;
    endproperty
    a_ext_delay: assert property (p_ext_delay)
        else $error("extension cut short");

    property p_clock_seen;
        @(posedge i_clk) disable iff (i_srst)
        tck_edge |=> st_reg.clocked;
    endproperty
    a_clock_seen: assert property (p_clock_seen)
        else $error("clocked mode missed");

    property p_clock_lost;
        @(posedge i_clk) disable iff (i_srst)
        st_reg.clocked && !tck_edge && st_reg.clk_to == 6'h14
        |=> !st_reg.clocked;
    endproperty
    a_clock_lost: assert property (p_clock_lost)
        else $error("clock loss missed");

    property p_pulse_width;
        @(posedge i_clk) disable iff (i_srst)
        $rose(st_reg.tx_p) && st_reg.clocked && $past(tck_edge) && !tck_edge
        |-> st_reg.tx_p ##1 (st_reg.tx_p || !st_reg.drv_en)
        ##1 (!st_reg.tx_p || tck_edge || $past(tck_edge));
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("pulse width wrong");

    property p_hiz;
        @(posedge i_clk) disable iff (i_srst)
        st_reg.txp_s2 && st_reg.txm_s2
        |=> !o_tx_drive_en && !o_tx_line.positive;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("driver left on");

    property p_stuck_low;
        @(posedge i_clk) disable iff (i_srst)
        !st_reg.clocked && !st_reg.tck_s2 |=> !o_tx_drive_en;
    endproperty
    a_stuck_low: assert property (p_stuck_low)
        else $error("driver on, clock low");

    property p_decl_event;
        @(posedge i_clk) disable iff (i_srst)
        $rose(o_signal_absent_flag) |-> st_reg.int_stat[`E1S_INT_DECL];
    endproperty
    a_decl_event: assert property (p_decl_event)
        else $error("declare event not latched");

    property p_clr_event;
        @(posedge i_clk) disable iff (i_srst)
        $fell(o_signal_absent_flag) |-> st_reg.int_stat[`E1S_INT_CLR];
    endproperty
    a_clr_event: assert property (p_clr_event)
        else $error("clear event not latched");

    property p_tx_exclusive;
        @(posedge i_clk) disable iff (i_srst)
        !(o_tx_line.positive && o_tx_line.negative);
    endproperty
    a_tx_exclusive: assert property (p_tx_exclusive)
        else $error("both transmit rails driven");

    c_declare: cover property (@(posedge i_clk) disable iff (i_srst)
        $rose(o_signal_absent_flag));
    c_clear: cover property (@(posedge i_clk) disable iff (i_srst)
        $fell(o_signal_absent_flag));
    c_ext: cover property (@(posedge i_clk) disable iff (i_srst)
        $changed(o_signal_absent_flag) && $past(st_reg.ext_wait));
    c_clocked: cover property (@(posedge i_clk) disable iff (i_srst)
        $rose(st_reg.clocked));
endmodule : e1s_channel
`default_nettype wire

// ==== sim/e1s_framer_model.sv ====
// Framer model driving the transmit rails and the transmit clock
`timescale 1ns/100ps
`default_nettype none
module e1s_framer_model (
    input wire logic i_clk,
    input wire logic [1:0] i_mode,
    input wire e1s_pkg::e1s_rails_t i_data,
    output e1s_pkg::e1s_rails_t o_rail,
    output var logic o_tck
);
    import e1s_pkg::*;
    int ph = 0;
    // Modes: 0 open clock, 1 clocked, 2 clock held low, 3 rails floating
    always @(posedge i_clk) begin
        ph <= (ph + 1) % 5;
        case (i_mode)
            2'h0: begin
                o_tck <= 1'h1;
                o_rail <= (ph < 2) ? i_data : 2'h0;
            end
            2'h1: begin
                o_tck <= (ph < 2);
                if (ph == 3) o_rail <= i_data;
            end
            2'h2: begin
                o_tck <= 1'h0;
                o_rail <= i_data;
            end
            default: begin
                o_tck <= 1'h1;
                o_rail <= 2'h3;
            end
        endcase
    end
endmodule : e1s_framer_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for one E1 channel
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import e1s_pkg::*;
    logic i_clk = 1'h0;
    logic i_srst = 1'h1;
    e1s_apb_req_t apb = '0;
    e1s_apb_rsp_t rsp;
    e1s_rails_t rx = '0, rxo, txr, txd = '0, txl;
    logic dsel = 1'h1, ext = 1'h0, ext_run = 1'h0;
    logic tck, flag, den, irq, err, mk = 1'h0, mon = 1'h0;
    logic pwon = 1'h0, ton = 1'h0;
    logic [1:0] mode = 2'h3;
    logic [31:0] rd;
    int n_errors = 0, n_tests = 0, seed = 10, nc, c, cyc = 0, pw = 0;
    e1s_rails_t q[$], tq[$];
    always #50 i_clk = ~i_clk;
    e1s_channel i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_apb(apb),
        .o_apb(rsp), .i_rx_line(rx), .i_absence_delay_select(dsel),
        .i_absence_extension_clock(ext), .i_tx_rail(txr),
        .i_tx_bit_clock(tck), .o_rx_rail(rxo),
        .o_signal_absent_flag(flag), .o_tx_line(txl),
        .o_tx_drive_en(den), .o_irq(irq));
    e1s_framer_model i_fr (.i_clk(i_clk), .i_mode(mode), .i_data(txd),
        .o_rail(txr), .o_tck(tck));
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic rng(input string n, input int lo, input int hi,
                       input int v);
        n_tests++;
        if (v < lo || v > hi) begin
            $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, v);
            n_errors++;
        end
    endtask : rng
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        apb <= '{1'h1, 1'h0, w, a, d};
        @(posedge i_clk);
        apb.penable <= 1'h1;
        @(posedge i_clk);
        while (rsp.pready !== 1'h1) @(posedge i_clk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        apb <= '0;
    endtask : bus
    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                        input string n);
        bus(1'h0, a, 32'h0);
        chk(n, e, rd);
    endtask : rchk
    task automatic wflag(input logic v, output int n);
        n = 0;
        while (flag !== v) begin
            @(posedge i_clk);
            n++;
        end
    endtask : wflag
    task automatic end_sim;
        if (n_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // Delay-line model of both rail paths, pulse width and stimulus
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (mon && q.size() > 3) chk("rx_rail", q[q.size()-3], rxo);
        if (ton) chk("tx_line", tq[tq.size()-3], txl);
        q.push_back(rx);
        tq.push_back(txr);
        rx <= (mk && cyc[0]) ? (($random(seed) & 1) ? 2'h2 : 2'h1) : 2'h0;
        txd <= 2'({$random(seed)} % 3);
        if (ext_run && cyc[0]) ext <= ~ext;
        if (txl.positive) begin
            pw <= pw + 1;
        end else begin
            if (pwon && pw != 0) chk("pulse_w", 2, pw);
            pw <= 0;
        end
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_srst <= 1'h0;
        mon <= 1'h1;
        chk("flag_rst", 1, flag);
        rchk(12'h000, 32'h2020, "cfg");
        rchk(12'h00C, 32'h0, "mask");
        rchk(12'h008, 32'h0, "istat");
        bus(1'h1, 12'h004, 32'hFFFFFFFF);
        rchk(12'h004, 32'h1, "status");
        rchk(12'h010, 32'h0, "unmapped");
        chk("slverr", 1, err);
        nc = 10 + ({$random(seed)} % 20);
        bus(1'h1, 12'h000, {16'h0, nc[7:0], 8'h03});
        rchk(12'h000, {16'h0, nc[7:0], 8'h0A}, "cfg_min");
        bus(1'h1, 12'h00C, 32'h7);
        mk <= 1'h1;
        wflag(1'h0, c);
        rng("clear_t", (nc - 1) * 5, (nc + 1) * 5 + 6, c);
        rchk(12'h008, 32'h2, "istat_clr");
        chk("irq_on", 1, irq);
        bus(1'h1, 12'h008, 32'h2);
        rchk(12'h00C, 32'h7, "mask_rd");
        chk("irq_w1c", 0, irq);
        bus(1'h1, 12'h00C, 32'h2);
        mk <= 1'h0;
        wflag(1'h1, c);
        rng("decl_t", 45, 61, c);
        rchk(12'h008, 32'h1, "istat_decl");
        chk("irq_masked", 0, irq);
        bus(1'h1, 12'h00C, 32'h1);
        rchk(12'h00C, 32'h1, "mask_rd2");
        chk("irq_unmasked", 1, irq);
        bus(1'h1, 12'h008, 32'h7);
        dsel <= 1'h0;
        ext_run <= 1'h1;
        mk <= 1'h1;
        wflag(1'h0, c);
        rng("ext_t", 8192 + (nc - 1) * 5 - 10,
            8192 + (nc + 1) * 5 + 30, c);
        ext_run <= 1'h0;
        bus(1'h1, 12'h008, 32'h7);
        mode <= 2'h1;
        repeat (30) @(posedge i_clk);
        pwon <= 1'h1;
        rchk(12'h004, 32'h6, "st_clocked");
        rchk(12'h008, 32'h4, "istat_mode");
        repeat (40) @(posedge i_clk);
        pwon <= 1'h0;
        mode <= 2'h0;
        repeat (40) @(posedge i_clk);
        rchk(12'h004, 32'h4, "st_clockless");
        ton <= 1'h1;
        repeat (40) @(posedge i_clk);
        ton <= 1'h0;
        mode <= 2'h2;
        repeat (12) @(posedge i_clk);
        chk("den_clk_low", 0, den);
        mode <= 2'h3;
        repeat (12) @(posedge i_clk);
        chk("den_float", 0, den);
        end_sim();
    end
    initial begin
        #(40000 * 100);
        $display("mismatch watchdog expected done seen timeout");
        n_errors++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
